// >>> verilog/mbp_pkg.sv
package mbp_pkg;

	// Register word indices; AXI byte offset is four times the index
	localparam logic [1:0] IDX_RATE  = 2'h0;
	localparam logic [1:0] IDX_CTRL  = 2'h1;
	localparam logic [1:0] IDX_FLAG  = 2'h2;
	localparam logic [1:0] IDX_VALID = 2'h3;
	localparam logic [7:0] NUM_REGS  = 8'h04;

	// Field positions
	localparam int RATE_W        = 4;
	localparam int RATE_LSB      = 0;
	localparam int CTRL_SQUARE_WAVE_ENABLE_BIT = 3;
	localparam int CTRL_EN_LSB   = 4;
	localparam int FLAG_LSB      = 4;
	localparam int FLAG_IRQ_BIT  = 7;
	localparam int VALID_BIT     = 7;
	localparam int NUM_INT       = 3;

	// Reset values
	localparam logic [RATE_W-1:0]  RATE_RST = 4'h0;
	localparam logic [NUM_INT-1:0] EN_RST   = 3'h0;
	localparam logic [NUM_INT-1:0] FLAG_RST = 3'h0;

	// Divider chain and square-wave taps
	localparam int         CHAIN_W  = 22;
	localparam logic [4:0] TAP_BASE = 5'h06;
	localparam int         QUART_W  = 2;

	// Pin synchroniser width
	localparam int SYNC_W = 18;

	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef enum logic {
		MBP_IDLE,
		MBP_LATCHED
	} mbp_state_t;

	typedef struct packed {
		logic       timebase;
		logic       div_sel;
		logic       strap;
		logic       ps;
		logic       init_n;
		logic       standby_n_n;
		logic       cs_n;
		logic       rw;
		logic       ds;
		logic       as;
		logic [7:0] ad;
	} mbp_pins_t;

	typedef struct packed {
		logic       hit;
		logic [1:0] idx;
	} mbp_sel_t;

	function automatic mbp_sel_t mbp_decode(input logic [7:0] w);
		mbp_sel_t r;
		r.hit = (w < NUM_REGS);
		r.idx = w[1:0];
		return r;
	endfunction

endpackage

// >>> verilog/mbp_divider.sv
`timescale 1ns/1ns
module mbp_divider
	import mbp_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              timebase,
	input  wire logic              div_sel,
	input  wire logic [RATE_W-1:0] rate,
	output logic                   clk_out,
	output logic                   tap,
	output logic                   tap_rise
);

	logic [CHAIN_W-1:0] chain_q, chain_d;
	logic [QUART_W-1:0] quart_q, quart_d;
	logic               tb_prev_q;
	logic               clk_out_q, clk_out_d;
	logic               tap_q, tap_d;
	logic               tap_rise_q, tap_rise_d;
	logic               tb_rise;
	logic [4:0]         tap_idx;

	assign tb_rise = timebase && !tb_prev_q;
	assign tap_idx = {1'b0, rate} + TAP_BASE;

	always_comb begin
		chain_d    = tb_rise ? chain_q + 22'h1 : chain_q;
		quart_d    = tb_rise ? quart_q + 2'h1 : quart_q;
		// Top bit of a two-bit count gives a quarter of the time base
		clk_out_d  = div_sel ? timebase : quart_q[QUART_W-1];
		tap_d      = (rate == RATE_RST) ? 1'b0 : chain_q[tap_idx];
		tap_rise_d = tap_d && !tap_q;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chain_q    <= '0;
			quart_q    <= '0;
			tb_prev_q  <= 1'b0;
			clk_out_q  <= 1'b0;
			tap_q      <= 1'b0;
			tap_rise_q <= 1'b0;
		end else begin
			chain_q    <= chain_d;
			quart_q    <= quart_d;
			tb_prev_q  <= timebase;
			clk_out_q  <= clk_out_d;
			tap_q      <= tap_d;
			tap_rise_q <= tap_rise_d;
		end
	end

	assign clk_out  = clk_out_q;
	assign tap      = tap_q;
	assign tap_rise = tap_rise_q;

endmodule // mbp_divider

// >>> verilog/mbp_port.sv
`timescale 1ns/1ns
module mbp_port
	import mbp_pkg::*;
(
	input  wire logic        REF_CLK,
	input  wire logic        RST,
	input  wire logic [7:0]  MUXED_ADDR_DATA_I,
	output logic      [7:0]  MUXED_ADDR_DATA_O,
	output logic             MUXED_ADDR_DATA_OE,
	input  wire logic        ADDRESS_STROBE,
	input  wire logic        DATA_STROBE,
	input  wire logic        READ_WRITE,
	input  wire logic        CHIP_SELECT_N,
	output logic             IRQ_N_O,
	output logic             IRQ_N_OE,
	input  wire logic        STANDBY_N,
	input  wire logic        INIT_IN_N,
	input  wire logic        POWER_SENSE_IN,
	input  wire logic        BUS_STYLE_STRAP,
	input  wire logic        CLOCK_OUT_DIVIDE_SELECT,
	input  wire logic        TIMEBASE_IN,
	output logic             CLOCK_OUTPUT,
	output logic             SQUARE_WAVE_OUT,
	input  wire logic        ALARM_EVENT,
	input  wire logic        UPDATE_EVENT,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	output logic      [1:0]  S_AXI_BRESP,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	output logic      [31:0] S_AXI_RDATA,
	output logic      [1:0]  S_AXI_RRESP
);

	mbp_pins_t          sync1_q, pin, prev_q;
	mbp_state_t         state_q, state_d;
	logic [7:0]         addr_q, addr_d;
	logic [7:0]         ad_out_q, ad_out_d;
	logic               ad_oe_q, ad_oe_d;
	logic [RATE_W-1:0]  rate_q, rate_d;
	logic [NUM_INT-1:0] en_q, en_d;
	logic [NUM_INT-1:0] flag_q, flag_d;
	logic               sqw_en_q, sqw_en_d;
	logic               valid_q, valid_d;
	logic               open_q, open_d;
	logic               blocked_q, blocked_d;
	logic               irq_oe_q, irq_oe_d;
	logic               sqw_q, sqw_d;
	logic               aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic               awready_q, awready_d, wready_q, wready_d;
	logic [7:0]         awaddr_q, awaddr_d;
	logic [7:0]         wdata_q, wdata_d;
	logic               wstrb_q, wstrb_d;
	logic               bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic               arready_q, arready_d;
	logic [1:0]         bresp_q, bresp_d, rresp_q, rresp_d;
	logic [7:0]         rdata_q, rdata_d;
	logic [7:0]         rd_word [4];
	logic               tap, tap_rise;
	logic               as_fall, as_rise, rd_act, rd_end, wr_end, data_end;
	logic               access_ok, pending, pin_wr, pin_rd;
	logic               aw_hs, w_hs, ar_hs, do_wr;
	mbp_sel_t           pin_sel, aw_sel, ar_sel;

	// Every pin is asynchronous to REF_CLK
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			sync1_q <= '0;
			pin     <= '0;
			prev_q  <= '0;
		end else begin
			sync1_q <= {TIMEBASE_IN, CLOCK_OUT_DIVIDE_SELECT, BUS_STYLE_STRAP,
				POWER_SENSE_IN, INIT_IN_N, STANDBY_N, CHIP_SELECT_N,
				READ_WRITE, DATA_STROBE, ADDRESS_STROBE, MUXED_ADDR_DATA_I};
			pin     <= sync1_q;
			prev_q  <= pin;
		end
	end

	mbp_divider u_div (
		.clk      (REF_CLK),
		.rst      (RST),
		.timebase (pin.timebase),
		.div_sel  (pin.div_sel),
		.rate     (rate_q),
		.clk_out  (CLOCK_OUTPUT),
		.tap      (tap),
		.tap_rise (tap_rise)
	);

	assign as_fall = prev_q.as && !pin.as;
	assign as_rise = !prev_q.as && pin.as;
	// Strap selects how the two strobe pins are read
	assign rd_act  = pin.strap ? (pin.ds && pin.rw) : !pin.ds;
	assign rd_end  = pin.strap ? (prev_q.ds && !pin.ds && prev_q.rw)
		: (!prev_q.ds && pin.ds);
	assign wr_end  = pin.strap ? (prev_q.ds && !pin.ds && !prev_q.rw)
		: (!prev_q.rw && pin.rw);
	assign data_end = pin.strap ? (prev_q.ds && !pin.ds)
		: ((!prev_q.ds && pin.ds) || wr_end);

	assign access_ok = (state_q == MBP_LATCHED) && !pin.cs_n && !blocked_q;
	assign pin_sel   = mbp_decode(addr_q);
	assign pin_wr    = access_ok && wr_end && pin_sel.hit;
	assign pin_rd    = access_ok && rd_end && pin_sel.hit;
	assign pending   = |(flag_q & en_q);

	assign aw_hs  = S_AXI_AWVALID && awready_q;
	assign w_hs   = S_AXI_WVALID && wready_q;
	assign ar_hs  = S_AXI_ARVALID && arready_q;
	assign do_wr  = aw_have_q && w_have_q && !bvalid_q;
	assign aw_sel = mbp_decode({2'h0, awaddr_q[7:2]});
	assign ar_sel = mbp_decode({2'h0, S_AXI_ARADDR[7:2]});

	always_comb begin
		rd_word[IDX_RATE]  = '0;
		rd_word[IDX_CTRL]  = '0;
		rd_word[IDX_FLAG]  = '0;
		rd_word[IDX_VALID] = '0;
		rd_word[IDX_RATE][RATE_LSB +: RATE_W]     = rate_q;
		rd_word[IDX_CTRL][CTRL_EN_LSB +: NUM_INT] = en_q;
		rd_word[IDX_CTRL][CTRL_SQUARE_WAVE_ENABLE_BIT]          = sqw_en_q;
		rd_word[IDX_FLAG][FLAG_LSB +: NUM_INT]    = flag_q;
		rd_word[IDX_FLAG][FLAG_IRQ_BIT]           = pending;
		rd_word[IDX_VALID][VALID_BIT]             = valid_q;
	end

	always_comb begin
		state_d   = state_q;
		addr_d    = addr_q;
		case (state_q)
			MBP_IDLE: begin
				if (as_fall && !pin.cs_n) begin
					addr_d  = pin.ad;
					state_d = MBP_LATCHED;
				end
			end
			MBP_LATCHED: begin
				if (data_end || as_rise) begin
					state_d = MBP_IDLE;
				end
			end
			default: state_d = MBP_IDLE;
		endcase
		// Registered drive lags the strobe by one REF_CLK cycle
		ad_oe_d  = access_ok && rd_act && pin_sel.hit;
		ad_out_d = rd_word[pin_sel.idx];
		// Transparent while open; current cycle already used the old value
		open_d    = open_q;
		blocked_d = open_q ? !pin.standby_n_n : blocked_q;
		if (data_end) begin
			open_d    = 1'b1;
			blocked_d = !pin.standby_n_n;
		end else if (as_rise) begin
			open_d = 1'b0;
		end
	end

	always_comb begin
		aw_have_d = aw_have_q || aw_hs;
		w_have_d  = w_have_q || w_hs;
		awaddr_d  = aw_hs ? S_AXI_AWADDR : awaddr_q;
		wdata_d   = w_hs ? S_AXI_WDATA[7:0] : wdata_q;
		wstrb_d   = w_hs ? S_AXI_WSTRB[0] : wstrb_q;
		bvalid_d  = bvalid_q && !S_AXI_BREADY;
		bresp_d   = bresp_q;
		rate_d    = rate_q;
		en_d      = en_q;
		sqw_en_d  = sqw_en_q;
		if (do_wr) begin
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = aw_sel.hit ? AXI_OKAY : AXI_SLVERR;
			if (aw_sel.hit && wstrb_q && aw_sel.idx == IDX_RATE) begin
				rate_d = wdata_q[RATE_LSB +: RATE_W];
			end
			if (aw_sel.hit && wstrb_q && aw_sel.idx == IDX_CTRL) begin
				en_d     = wdata_q[CTRL_EN_LSB +: NUM_INT];
				sqw_en_d = wdata_q[CTRL_SQUARE_WAVE_ENABLE_BIT];
			end
		end
		// A pin write in the same cycle lands after the AXI one
		if (pin_wr && pin_sel.idx == IDX_RATE) begin
			rate_d = prev_q.ad[RATE_LSB +: RATE_W];
		end
		if (pin_wr && pin_sel.idx == IDX_CTRL) begin
			en_d     = prev_q.ad[CTRL_EN_LSB +: NUM_INT];
			sqw_en_d = prev_q.ad[CTRL_SQUARE_WAVE_ENABLE_BIT];
		end
		awready_d = !aw_have_d && !bvalid_d;
		wready_d  = !w_have_d && !bvalid_d;
		rvalid_d  = rvalid_q && !S_AXI_RREADY;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		if (ar_hs) begin
			rvalid_d = 1'b1;
			rdata_d  = ar_sel.hit ? rd_word[ar_sel.idx] : 8'h00;
			rresp_d  = ar_sel.hit ? AXI_OKAY : AXI_SLVERR;
		end
		arready_d = !rvalid_d;
		// New events win over a read clear in the same cycle
		flag_d = flag_q | {tap_rise, ALARM_EVENT, UPDATE_EVENT};
		if ((pin_rd && pin_sel.idx == IDX_FLAG)
			|| (ar_hs && ar_sel.hit && ar_sel.idx == IDX_FLAG)) begin
			flag_d = {tap_rise, ALARM_EVENT, UPDATE_EVENT};
		end
		valid_d = valid_q;
		if ((pin_rd && pin_sel.idx == IDX_VALID)
			|| (ar_hs && ar_sel.hit && ar_sel.idx == IDX_VALID)) begin
			valid_d = 1'b1;
		end
		if (!pin.ps) begin
			valid_d = 1'b0;
		end
		// Rate and divider are deliberately outside the init clear
		if (!pin.init_n) begin
			en_d     = EN_RST;
			flag_d   = FLAG_RST;
			sqw_en_d = 1'b0;
		end
		irq_oe_d = pending && pin.init_n;
		sqw_d    = sqw_en_q && tap;
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			state_q   <= MBP_IDLE;
			addr_q    <= '0;
			ad_out_q  <= '0;
			ad_oe_q   <= 1'b0;
			rate_q    <= RATE_RST;
			en_q      <= EN_RST;
			flag_q    <= FLAG_RST;
			sqw_en_q  <= 1'b0;
			valid_q   <= 1'b0;
			open_q    <= 1'b0;
			blocked_q <= 1'b0;
			irq_oe_q  <= 1'b0;
			sqw_q     <= 1'b0;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= '0;
			wstrb_q   <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= AXI_OKAY;
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= AXI_OKAY;
		end else begin
			state_q   <= state_d;
			addr_q    <= addr_d;
			ad_out_q  <= ad_out_d;
			ad_oe_q   <= ad_oe_d;
			rate_q    <= rate_d;
			en_q      <= en_d;
			flag_q    <= flag_d;
			sqw_en_q  <= sqw_en_d;
			valid_q   <= valid_d;
			open_q    <= open_d;
			blocked_q <= blocked_d;
			irq_oe_q  <= irq_oe_d;
			sqw_q     <= sqw_d;
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			awaddr_q  <= awaddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

	assign MUXED_ADDR_DATA_O  = ad_out_q;
	assign MUXED_ADDR_DATA_OE = ad_oe_q;
	assign IRQ_N_O            = 1'b0;
	assign IRQ_N_OE           = irq_oe_q;
	assign SQUARE_WAVE_OUT    = sqw_q;
	assign S_AXI_AWREADY      = awready_q;
	assign S_AXI_WREADY       = wready_q;
	assign S_AXI_BVALID       = bvalid_q;
	assign S_AXI_BRESP        = bresp_q;
	assign S_AXI_ARREADY      = arready_q;
	assign S_AXI_RVALID       = rvalid_q;
	assign S_AXI_RDATA        = {24'h000000, rdata_q};
	assign S_AXI_RRESP        = rresp_q;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	sequence s_rate_write(logic style);
		pin.strap == style && access_ok && wr_end && pin_sel.hit
			&& pin_sel.idx == IDX_RATE;
	endsequence

	sequence s_init_held;
		!pin.init_n ##1 !pin.init_n;
	endsequence

	addr_latch_a: assert property (
		state_q == MBP_IDLE && as_fall && !pin.cs_n
		|=> state_q == MBP_LATCHED && addr_q == $past(pin.ad))
		else $error("address not latched at strobe fall");
	no_select_a: assert property (
		state_q == MBP_IDLE && pin.cs_n |=> state_q == MBP_IDLE)
		else $error("cycle taken without chip select");
	strobe_write_a: assert property (
		s_rate_write(1'b1) |=> rate_q == $past(prev_q.ad[RATE_W-1:0]))
		else $error("strobe style write lost");
	pulse_write_a: assert property (
		s_rate_write(1'b0) |=> rate_q == $past(prev_q.ad[RATE_W-1:0]))
		else $error("pulse style write lost");
	read_release_a: assert property (
		(pin.strap && $fell(pin.ds)) or (!pin.strap && $rose(pin.ds))
		|=> !MUXED_ADDR_DATA_OE)
		else $error("bus not released at strobe end");
	irq_hold_a: assert property (
		pending && pin.init_n |=> IRQ_N_OE && !IRQ_N_O)
		else $error("request not asserted");
	irq_float_a: assert property (
		!pending |=> !IRQ_N_OE)
		else $error("request driven without cause");
	init_clear_a: assert property (
		s_init_held |-> en_q == EN_RST && flag_q == FLAG_RST
			&& !sqw_en_q && !IRQ_N_OE)
		else $error("init did not clear control bits");
	valid_clear_a: assert property (
		!pin.ps |=> !valid_q)
		else $error("valid flag survived power sense low");
	clock_output_full_a: assert property (
		$past(pin.div_sel) |-> CLOCK_OUTPUT == $past(pin.timebase))
		else $error("clock output not at time base rate");

endmodule // mbp_port

// >>> testbench/mbp_host_model.sv
`timescale 1ns/1ns
module mbp_host_model (
	input  wire logic       clk,
	input  wire logic       strap,
	input  wire logic [7:0] dev_ad,
	input  wire logic       dev_oe,
	output logic      [7:0] bus,
	output logic            as_o,
	output logic            ds_o,
	output logic            rw_o,
	output logic            cs_n
);
	logic [7:0] h_ad   = 8'h00;
	logic       h_oe   = 1'b0;
	logic       ds_act = 1'b0;
	logic       wr_act = 1'b0;
	logic [7:0] last_q = 8'h00;

	initial as_o = 1'b0;
	initial cs_n = 1'b1;
	// Released lines toggle so a stale copy can never pass for data
	assign bus  = dev_oe ? dev_ad : (h_oe ? h_ad : ~last_q);
	assign ds_o = strap ? ds_act : ~ds_act;
	assign rw_o = ~wr_act;
	always @(posedge clk) last_q <= bus;

	task automatic cycle(input logic wr, input logic sel, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		q = 8'h00;
		@(posedge clk);
		cs_n <= ~sel;
		h_oe <= 1'b1;
		h_ad <= a;
		as_o <= 1'b1;
		repeat (4) @(posedge clk);
		as_o <= 1'b0;
		repeat (4) @(posedge clk);
		if (wr) begin
			h_ad <= d;
			wr_act <= 1'b1;
			ds_act <= strap;
			repeat (4) @(posedge clk);
			ds_act <= 1'b0;
			repeat (2) @(posedge clk);
			wr_act <= 1'b0;
			repeat (3) @(posedge clk);
			h_oe <= 1'b0;
		end else begin
			h_oe <= 1'b0;
			ds_act <= 1'b1;
			repeat (6) @(posedge clk);
			q = bus;
			ds_act <= 1'b0;
			repeat (6) @(posedge clk);
		end
		cs_n <= 1'b1;
	endtask
endmodule // mbp_host_model

// >>> testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top
	import mbp_pkg::*;
;
	logic        clk = 1'b0, rst = 1'b1, init_n = 1'b1, ps = 1'b1;
	logic        strap = 1'b1, div = 1'b1, tbase = 1'b0, standby_n_n = 1'b1;
	logic        alarm = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
	logic        arv = 1'b0, rry = 1'b0, upd = 1'b0;
	logic [7:0]  awa = 8'h00, ara = 8'h00, ad_o, ad_i;
	logic [31:0] wd = 32'h0, rd;
	logic        ad_oe, irq_o, irq_oe, ck, sq, awr, wrr, bv, arr, rv;
	logic        as_p, ds_p, rw_p, cs_n;
	logic [1:0]  br, rr;
	int          fails = 0, cmp_count = 0, cyc = 0;
	wire         irq_line = irq_oe ? irq_o : 1'b1;

	always #10 clk = ~clk;
	always begin
		repeat (4) @(posedge clk);
		tbase <= ~tbase;
	end

	mbp_host_model i_host (.clk(clk), .strap(strap), .dev_ad(ad_o),
		.dev_oe(ad_oe), .bus(ad_i), .as_o(as_p), .ds_o(ds_p), .rw_o(rw_p),
		.cs_n(cs_n));

	mbp_port i_mbp_port (.REF_CLK(clk), .RST(rst), .MUXED_ADDR_DATA_I(ad_i),
		.MUXED_ADDR_DATA_O(ad_o), .MUXED_ADDR_DATA_OE(ad_oe),
		.ADDRESS_STROBE(as_p), .DATA_STROBE(ds_p), .READ_WRITE(rw_p),
		.CHIP_SELECT_N(cs_n), .IRQ_N_O(irq_o), .IRQ_N_OE(irq_oe),
		.STANDBY_N(standby_n_n), .INIT_IN_N(init_n), .POWER_SENSE_IN(ps),
		.BUS_STYLE_STRAP(strap), .CLOCK_OUT_DIVIDE_SELECT(div),
		.TIMEBASE_IN(tbase), .CLOCK_OUTPUT(ck), .SQUARE_WAVE_OUT(sq),
		.ALARM_EVENT(alarm), .UPDATE_EVENT(upd), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wrr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
		.S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_BRESP(br),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .S_AXI_RDATA(rd),
		.S_AXI_RRESP(rr));

	task automatic tally_and_finish();
		if (fails == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge clk);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		bry <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrr) wv <= 1'b0;
		end while (bv !== 1'b1);
		bry <= 1'b0;
		chk(32'(br), 32'(er));
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rry <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		rry <= 1'b0;
		chk(32'(rr), 32'(er));
		chk(rd, ed);
	endtask

	task automatic pin_wr(input logic sel, input logic [7:0] a,
		input logic [7:0] d);
		logic [7:0] q;
		i_host.cycle(1'b1, sel, a, d, q);
	endtask

	task automatic pin_rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		i_host.cycle(1'b0, 1'b1, a, 8'h00, q);
		chk(32'(q), 32'(e));
		chk(32'(ad_oe), 32'h0);
	endtask

	// Counts rising edges of the clock and square-wave outputs
	task automatic rises(input int n, output int nc, output int ns);
		logic pc, psq;
		nc = 0;
		ns = 0;
		pc = ck;
		psq = sq;
		repeat (n) begin
			@(posedge clk);
			nc += int'(ck && !pc);
			ns += int'(sq && !psq);
			pc = ck;
			psq = sq;
		end
	endtask

	initial begin
		int nc, ns;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		axi_rd(8'h04, 32'h0, AXI_OKAY);
		axi_rd(8'h10, 32'h0, AXI_SLVERR);
		axi_wr(8'h10, 32'h0, AXI_SLVERR);
		pin_wr(1'b1, 8'h01, 8'h28);
		axi_rd(8'h04, 32'h28, AXI_OKAY);
		pin_wr(1'b0, 8'h01, 8'h00);
		axi_rd(8'h04, 32'h28, AXI_OKAY);
		pin_rd(8'h01, 8'h28);
		chk(32'(irq_line), 32'h1);
		alarm <= 1'b1;
		upd <= 1'b1;
		@(posedge clk);
		alarm <= 1'b0;
		upd <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'(irq_line), 32'h0);
		pin_rd(8'h02, 8'hb0);
		repeat (3) @(posedge clk);
		chk(32'(irq_line), 32'h1);
		axi_wr(8'h00, 32'h1, AXI_OKAY);
		rises(400, nc, ns);
		chk(32'(nc >= 49 && nc <= 51), 32'h1);
		div <= 1'b0;
		rises(400, nc, ns);
		chk(32'(nc >= 11 && nc <= 14), 32'h1);
		rises(4500, nc, ns);
		chk(32'(ns > 0), 32'h1);
		chk(32'(irq_line), 32'h1);
		// Just after a tap rise, so no new periodic flag before the reads
		@(posedge sq);
		@(posedge clk);
		init_n <= 1'b0;
		repeat (6) @(posedge clk);
		init_n <= 1'b1;
		repeat (4) @(posedge clk);
		axi_rd(8'h08, 32'h0, AXI_OKAY);
		axi_rd(8'h04, 32'h0, AXI_OKAY);
		axi_rd(8'h00, 32'h1, AXI_OKAY);
		rises(1200, nc, ns);
		chk(32'(ns), 32'h0);
		ps <= 1'b0;
		repeat (4) @(posedge clk);
		axi_rd(8'h0c, 32'h0, AXI_OKAY);
		ps <= 1'b1;
		repeat (4) @(posedge clk);
		axi_rd(8'h0c, 32'h0, AXI_OKAY);
		axi_rd(8'h0c, 32'h80, AXI_OKAY);
		ps <= 1'b0;
		repeat (4) @(posedge clk);
		axi_rd(8'h0c, 32'h0, AXI_OKAY);
		standby_n_n <= 1'b0;
		pin_wr(1'b1, 8'h01, 8'h40);
		axi_rd(8'h04, 32'h0, AXI_OKAY);
		standby_n_n <= 1'b1;
		pin_wr(1'b1, 8'h01, 8'h40);
		axi_rd(8'h04, 32'h40, AXI_OKAY);
		rst <= 1'b1;
		strap <= 1'b0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		pin_wr(1'b1, 8'h00, 8'h03);
		axi_rd(8'h00, 32'h3, AXI_OKAY);
		pin_rd(8'h00, 8'h03);
		tally_and_finish();
	end
endmodule // tb_top
